// [brs_bus_reset_sequencer.sv]
// bus reset sequencer with shared watchdog counter chain
// assumes bus inputs already synchronous to ref_clk_i
//
// What this block does
// [RQ1] run input drops on every system reset
// [RQ2] run low: gate closed, chain held cleared
// [RQ3] run high after reset enters counting state
// [RQ4] counting: chain runs, errors suppressed, reset strobe
// [RQ5] stay counting until chain terminal count
// [RQ6] terminal count: gate opens, enter run state
// [RQ7] leaving count releases strobe, busy retriggers
// [RQ8] run state held until run drops
// [RQ9] mod-250 chain enables mod-40, 10000 cycles
// [RQ10] in run, busy assertion starts chain
// [RQ11] in run, busy low holds chain cleared
// [RQ12] busy at terminal count pulses error, ready
// [RQ13] registers on rising clock, chain from zero
`timescale 1ns/1ps
`include "brs_cfg.svh"
module brs_bus_reset_sequencer #(
  // counter chain moduli, low stage first
  parameter int LO_MOD = `BRS_LO_MOD,
  parameter int HI_MOD = `BRS_HI_MOD
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // system control
  input  wire logic run_i,
  input  wire logic bus_busy_i,
  // bus outputs, active high here
  output logic      bus_reset_o,
  output logic      bus_err_o,
  output logic      bus_rdy_o,
  output logic      bus_rty_o,
  output logic      busy_gate_o,
  output logic      interval_active_o,
  output logic      chain_terminal_count_o
);

  // stage widths come from the shared header so the state struct matches
  localparam int LO_W = `BRS_LO_W;
  localparam int HI_W = `BRS_HI_W;

  // last value of each stage; a modulus too big for its width wraps early
  localparam logic [LO_W-1:0] LO_LAST = LO_W'(LO_MOD - 1);
  localparam logic [HI_W-1:0] HI_LAST = HI_W'(HI_MOD - 1);

  // clear values and unit steps of each stage
  localparam logic [LO_W-1:0] LO_CLR  = `BRS_LO_ZERO;
  localparam logic [HI_W-1:0] HI_CLR  = `BRS_HI_ZERO;
  localparam logic [LO_W-1:0] LO_STEP = LO_W'(1);
  localparam logic [HI_W-1:0] HI_STEP = HI_W'(1);

  // state decodes, each used only by an output; the chain control decodes the state itself
  function automatic logic is_counting(input brs_pkg::brs_state_e st);
    is_counting = (st == brs_pkg::BRS_COUNT);
  endfunction

  function automatic logic is_running(input brs_pkg::brs_state_e st);
    is_running = (st == brs_pkg::BRS_RUN);
  endfunction

  // whether the chain may advance in this state
  function automatic logic chain_enabled(
    input brs_pkg::brs_state_e st,
    input logic                busy
  );
    chain_enabled = 1'b0;
    case (st)
      brs_pkg::BRS_COUNT: begin
        chain_enabled = 1'b1; // RQ4
      end
      brs_pkg::BRS_RUN: begin
        chain_enabled = busy; // RQ10 RQ11
      end
      default: begin
        chain_enabled = 1'b0; // RQ2
      end
    endcase
  endfunction

  brs_pkg::brs_s s_r;
  brs_pkg::brs_s s_nxt;
  logic          lo_last;
  logic          hi_last;
  logic          chain_end;
  logic          chain_run;

  // end of chain is the low stage carry into a high stage on its last value
  assign lo_last   = (s_r.lo == LO_LAST);
  assign hi_last   = (s_r.hi == HI_LAST);
  assign chain_end = lo_last && hi_last; // RQ9

  // busy only reaches the timer through the gate, i.e. in run
  assign chain_run = chain_enabled(s_r.state, bus_busy_i); // RQ2 RQ7 RQ10

  always_comb begin
    s_nxt           = s_r;
    s_nxt.err_pulse = 1'b0;

    // counter chain
    if (!chain_run) begin
      // idle or busy dropped: back to the initial count
      s_nxt.lo = LO_CLR; // RQ11
      s_nxt.hi = HI_CLR;
    end else if (chain_end) begin
      // wrap so a busy held past the end times out again
      s_nxt.lo = LO_CLR; // RQ9
      s_nxt.hi = HI_CLR;
    end else if (lo_last) begin
      // low stage carry enables the high stage for one step
      s_nxt.lo = LO_CLR; // RQ9
      s_nxt.hi = s_r.hi + HI_STEP;
    end else begin
      s_nxt.lo = s_r.lo + LO_STEP;
    end

    // sequencer
    case (s_r.state)
      brs_pkg::BRS_IDLE: begin
        if (run_i) begin
          s_nxt.state = brs_pkg::BRS_COUNT; // RQ3
        end
      end
      brs_pkg::BRS_COUNT: begin
        if (chain_end) begin
          s_nxt.state = brs_pkg::BRS_RUN; // RQ5 RQ6 RQ7
        end
      end
      brs_pkg::BRS_RUN: begin
        if (chain_end && bus_busy_i) begin
          s_nxt.err_pulse = 1'b1; // RQ12
        end
      end
      default: begin
        s_nxt.state = brs_pkg::BRS_IDLE;
      end
    endcase

    // a reset from outside always wins, whatever the state
    if (!run_i) begin
      s_nxt.state     = brs_pkg::BRS_IDLE; // RQ8
      s_nxt.lo        = LO_CLR; // RQ2
      s_nxt.hi        = HI_CLR;
      s_nxt.err_pulse = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r.state     <= brs_pkg::BRS_IDLE;
      s_r.lo        <= LO_CLR; // RQ13
      s_r.hi        <= HI_CLR;
      s_r.err_pulse <= 1'b0;
    end else begin
      s_r <= s_nxt; // RQ13
    end
  end

  // strobe and gate are plain decodes of the state register
  assign interval_active_o      = is_counting(s_r.state); // RQ3
  assign bus_reset_o            = is_counting(s_r.state); // RQ4 RQ7
  assign busy_gate_o            = is_running(s_r.state); // RQ6

  // error pulse is only ever set in run, so counting suppresses it
  assign bus_err_o              = s_r.err_pulse; // RQ4 RQ12
  assign bus_rdy_o              = s_r.err_pulse; // RQ12

  // retry is never raised by this block
  assign bus_rty_o              = 1'b0; // RQ4

  // limitation: a decode of the counters, not a flip-flop of its own
  assign chain_terminal_count_o = chain_end; // RQ9

endmodule

// [brs_bus_reset_sequencer_tb.sv]
// self-checking bench for the sequencer
// assumes design, model and checker compiled first
`timescale 1ns/1ps
module brs_bus_reset_sequencer_tb;
  logic ref_clk_i = 0, sys_rst_i = 1, run_i = 0, go = 0;
  logic bus_busy_i, bus_reset_o, bus_err_o, bus_rdy_o, bus_rty_o, busy_gate_o;
  logic interval_active_o, chain_terminal_count_o;
  int fail_count = 0, checked = 0, n;
  always #4 ref_clk_i = ~ref_clk_i;
  brs_bus_reset_sequencer i_brs_bus_reset_sequencer (.*);
  brs_master_model i_brs_master_model (.ref_clk_i, .go_i(go), .err_i(bus_err_o),
    .busy_o(bus_busy_i));
  task clk(input int k); repeat (k) @(negedge ref_clk_i); endtask
  task chk(input logic [15:0] a, b);
    checked++;
    if (a !== b) begin fail_count++; $display("MISMATCH %0t %h %h", $time, a, b); end
  endtask
  task report_and_stop;
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_interval;
    go = 1; clk(5); sys_rst_i = 0; clk(3);
    chk(busy_gate_o | interval_active_o, 0);
    run_i = 1; clk(1); chk(bus_reset_o, 1);
    for (n = 0; interval_active_o === 1'b1 && n < 10100; n++) clk(1);
    chk(n, 10000);
    if (n > 10099) report_and_stop;
    chk({busy_gate_o, bus_reset_o}, 2'b10);
  endtask
  // one idle cycle must restart the watchdog from zero
  task t_timeout;
    go = 0; clk(2); go = 1; clk(9000); go = 0; clk(1); go = 1;
    for (n = 0; chain_terminal_count_o !== 1'b1 && n < 10100; n++) clk(1);
    chk(n, 9999);
    if (n > 10099) report_and_stop;
    chk({bus_err_o, bus_rty_o}, 2'b00);
    clk(1); chk({bus_err_o, bus_rdy_o, chain_terminal_count_o}, 3'b110);
    clk(1); chk(bus_err_o, 0);
    run_i = 0; clk(2); chk(busy_gate_o, 0);
  endtask
  initial begin t_interval; t_timeout; report_and_stop; end
endmodule
bind brs_bus_reset_sequencer brs_checker i_brs_checker (.*);

// [brs_cfg.svh]
// constants for the bus reset sequencer
// assumes inclusion by bare name from the design files
`ifndef BRS_CFG_SVH
`define BRS_CFG_SVH
`define BRS_LO_MOD      250
`define BRS_HI_MOD      40
`define BRS_LO_W        8
`define BRS_HI_W        6
`define BRS_LO_LAST     8'hF9
`define BRS_HI_LAST     6'h27
`define BRS_LO_ZERO     8'h00
`define BRS_HI_ZERO     6'h00
`endif

// [brs_checker.sv]
// port assertions for the sequencer
// assumes a bind from the bench top file
`timescale 1ns/1ps
module brs_checker (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // system control
  input  wire logic run_i,
  input  wire logic bus_busy_i,
  // watched outputs
  input  wire logic bus_reset_o,
  input  wire logic bus_err_o,
  input  wire logic bus_rdy_o,
  input  wire logic bus_rty_o,
  input  wire logic busy_gate_o,
  input  wire logic interval_active_o,
  input  wire logic chain_terminal_count_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire cnt       = interval_active_o;
  wire chain_end = chain_terminal_count_o;
  run_low_a: assert property (!run_i |=> !busy_gate_o && !cnt) else $error("run low");
  count_start_a: assert property (run_i && !busy_gate_o && !cnt |=> cnt) else $error("start");
  count_out_a: assert property (cnt |-> bus_reset_o && !bus_err_o && !bus_rty_o)
    else $error("count outputs");
  count_hold_a: assert property (cnt && run_i && !chain_end |=> cnt) else $error("hold");
  count_end_a: assert property (cnt && run_i && chain_end |=> busy_gate_o && !bus_reset_o)
    else $error("count end");
  run_hold_a: assert property (busy_gate_o && run_i |=> busy_gate_o) else $error("run");
  chain_clear_a: assert property (busy_gate_o && !bus_busy_i |=> !chain_end) else $error("clear");
  err_pulse_a: assert property (busy_gate_o && run_i && bus_busy_i && chain_end |=>
    bus_err_o && bus_rdy_o ##1 !bus_err_o) else $error("error pulse");
endmodule

// [brs_master_model.sv]
// bus master model: busy while asked, dropped on error
// assumes it drives at the falling clock edge
`timescale 1ns/1ps
module brs_master_model (
  // clock
  input  wire logic ref_clk_i,
  // bench request and design error
  input  wire logic go_i,
  input  wire logic err_i,
  // busy toward the design
  output logic      busy_o
);
  logic ended_r = 1'b0;
  // error ends the transaction; go low re-arms; go_i is read on the same falling edge the bench drives it
  always @(negedge ref_clk_i) begin
    ended_r <= err_i | (ended_r & go_i);
  end
  assign busy_o = go_i & ~ended_r;
endmodule

// [brs_pkg.sv]
// types for the bus reset sequencer
// assumes brs_cfg.svh is on the include path
`include "brs_cfg.svh"
package brs_pkg;
  typedef enum logic [1:0] {
    BRS_IDLE  = 2'b00,
    BRS_COUNT = 2'b01,
    BRS_RUN   = 2'b11
  } brs_state_e;

  typedef struct packed {
    brs_state_e                 state;
    logic [`BRS_LO_W-1:0]       lo;
    logic [`BRS_HI_W-1:0]       hi;
    logic                       err_pulse;
  } brs_s;
endpackage
